/* rtl/adcc_ctrl.sv */
// adcc_ctrl: result fifo and control wrapper of the converter core
// assumes an Avalon-MM master on clk, an analog core on clk, asynchronous event lines
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// result fifo with valid/ready on both sides
module adcc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // honest full and empty from the occupancy count
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q];

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : adcc_fifo

////////////////////////////////////////////////////////////////////////////////
// top: bus slave, interrupts, events, sleep control and write synchronisation
module adcc_ctrl #(
   parameter int N_EV_START = 1,
   parameter int N_EV_FLUSH = 1,
   parameter int FIFO_DEPTH = 16,
   parameter int STARTUP    = adcc_pkg::STARTUP_CYCLES
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   // avalon-mm slave
   input  wire logic [9:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   // system side
   output logic                         dma_request,
   output logic                         irq,
   output logic                         wake_request,
   input  wire logic                    standby,
   input  wire logic [N_EV_START-1:0]   ev_start_in,
   input  wire logic [N_EV_FLUSH-1:0]   ev_flush_in,
   output logic                         ev_result_ready_out,
   output logic                         ev_window_match_out,
   // analog core side
   output logic                         core_power,
   output logic                         core_start,
   output logic                         core_flush,
   output logic [adcc_pkg::NUM_BUF-1:0][15:0] core_config,
   input  wire logic                    core_result_valid,
   input  wire logic                    core_avg_last,
   input  wire logic                    core_window_match,
   input  wire logic [15:0]             core_result_data,
   output logic                         core_result_ready
);
   logic [7:0]              idx;
   logic                    ack_q;
   logic                    wr_acc;
   logic                    rd_acc;
   logic                    srst;
   logic [7:0]              ctrl_a_q;
   logic                    enable_q;
   logic [$clog2(adcc_pkg::SYNC_STAGES+1)-1:0] en_cnt_q;
   logic [$clog2(adcc_pkg::SYNC_STAGES+1)-1:0] sr_cnt_q;
   logic                    sr_pend_q;
   adcc_pkg::adcc_event_control_t  evc_q;
   adcc_pkg::adcc_irq_t     flags_q;
   adcc_pkg::adcc_irq_t     irq_en_q;
   adcc_pkg::adcc_irq_t     flag_set;
   logic [adcc_pkg::NUM_BUF-1:0][15:0] shadow_q;
   logic [adcc_pkg::NUM_BUF-1:0]       buf_busy_q;
   logic [1:0]              trig_pend_q;
   logic                    stby_busy_q;
   logic                    standby_q;
   logic [N_EV_START-1:0]   st_m_q;
   logic [N_EV_START-1:0]   st_s_q;
   logic [N_EV_FLUSH-1:0]   fl_m_q;
   logic [N_EV_FLUSH-1:0]   fl_s_q;
   logic                    st_lvl_q;
   logic                    fl_lvl_q;
   logic                    st_lvl;
   logic                    fl_lvl;
   logic                    flush_req;
   logic                    start_req;
   logic                    run_ok;
   logic                    push;
   logic                    conv_end;
   logic                    pend_start_q;
   logic [$clog2(STARTUP+1)-1:0] warm_q;
   adcc_pkg::adcc_state_t   state_q;
   logic                    fifo_valid;
   logic [15:0]             fifo_data;
   logic [31:0]             rdata;
   logic [10:0]             sync_busy;

   // byte address to register index; the two low address bits are ignored
   assign idx    = avs_address[9:2];
   assign wr_acc = avs_write && ack_q;
   assign rd_acc = avs_read && ack_q;
   // one wait cycle per access; the access completes on the second edge
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

   always_ff @(posedge clk) begin
      if (rst) ack_q <= 1'b0;
      else     ack_q <= (avs_read || avs_write) && !ack_q;
   end

   // soft reset applied once its synchronisation completes
   assign srst = rst || (sr_pend_q && sr_cnt_q == '0);

   ////////////////////////////////////////////////////////////////////////////
   // control_a: enable and soft reset pass a fixed transfer delay
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_a_q  <= '0;
         enable_q  <= 1'b0;
         en_cnt_q  <= '0;
         sr_pend_q <= 1'b0;
         sr_cnt_q  <= '0;
      end else begin
         if (wr_acc && idx == adcc_pkg::IDX_CONTROL_A) begin
            ctrl_a_q <= avs_writedata[7:0] & adcc_pkg::CA_MASK & ~8'h01;
            en_cnt_q <= ($bits(en_cnt_q))'(adcc_pkg::SYNC_STAGES);
            if (avs_writedata[adcc_pkg::CA_SOFT_RESET]) begin
               sr_pend_q <= 1'b1;
               sr_cnt_q  <= ($bits(sr_cnt_q))'(adcc_pkg::SYNC_STAGES - 1);
            end
         end else if (en_cnt_q != '0) begin
            en_cnt_q <= en_cnt_q - 1'b1;
            if (en_cnt_q == ($bits(en_cnt_q))'(1)) enable_q <= ctrl_a_q[adcc_pkg::CA_ENABLE];
         end
         if (sr_pend_q && sr_cnt_q != '0) sr_cnt_q <= sr_cnt_q - 1'b1;
      end
   end

   // core may run only when enabled and standby permits it
   assign run_ok = enable_q && (!standby || ctrl_a_q[adcc_pkg::CA_RUN_STDBY]);

   ////////////////////////////////////////////////////////////////////////////
   // event control and interrupt enables
   always_ff @(posedge clk) begin
      if (srst) begin
         evc_q    <= '0;
         irq_en_q <= '0;
      end else if (wr_acc) begin
         if (idx == adcc_pkg::IDX_EVENT_CONTROL) evc_q <= avs_writedata[5:0];
         if (idx == adcc_pkg::IDX_IRQ_EN_SET)    irq_en_q <= irq_en_q | avs_writedata[2:0];
         if (idx == adcc_pkg::IDX_IRQ_EN_CLEAR)  irq_en_q <= irq_en_q & ~avs_writedata[2:0];
      end
   end

   // flags: write one clears, a coincident set wins
   always_ff @(posedge clk) begin
      if (srst) flags_q <= '0;
      else if (wr_acc && idx == adcc_pkg::IDX_IRQ_FLAGS) flags_q <= (flags_q & ~avs_writedata[2:0]) | flag_set;
      else flags_q <= flags_q | flag_set;
   end

   assign irq = |(flags_q & irq_en_q);
   // overrun is deliberately left out of the wake-up sources
   assign wake_request = standby && ((flags_q.result_ready && irq_en_q.result_ready) ||
                                     (flags_q.window_match && irq_en_q.window_match));

   ////////////////////////////////////////////////////////////////////////////
   // buffered configuration: bus shadow copy, moved to the core when it is not converting or on a result
   always_ff @(posedge clk) begin
      if (srst) begin
         shadow_q    <= '0;
         core_config <= '0;
         buf_busy_q  <= '0;
      end else begin
         for (int i = 0; i < adcc_pkg::NUM_BUF; i++) begin
            if (wr_acc && idx == adcc_pkg::BUF_IDX[i]) begin
               shadow_q[i]   <= avs_writedata[15:0] & adcc_pkg::BUF_MASK[i];
               buf_busy_q[i] <= 1'b1;
            end else if (buf_busy_q[i] && (state_q != adcc_pkg::ST_CONV || push)) begin
               core_config[i] <= shadow_q[i];
               buf_busy_q[i]  <= 1'b0;
            end
         end
      end
   end

   // soft trigger: pending bits taken by the sequencer next cycle; busy forced after standby exit
   always_ff @(posedge clk) begin
      if (srst) begin
         trig_pend_q <= '0;
         stby_busy_q <= 1'b0;
         standby_q   <= 1'b0;
      end else begin
         standby_q <= standby;
         if (wr_acc && idx == adcc_pkg::IDX_SOFT_TRIGGER) trig_pend_q <= avs_writedata[1:0];
         else trig_pend_q <= '0;
         if (standby_q && !standby) stby_busy_q <= 1'b1;
         else if (push) stby_busy_q <= 1'b0;
      end
   end

   assign sync_busy = {(trig_pend_q != '0) || stby_busy_q, buf_busy_q, en_cnt_q != '0, sr_pend_q};

   ////////////////////////////////////////////////////////////////////////////
   // event inputs: two-flop synchronisers, then combine, invert and detect edges
   always_ff @(posedge clk) begin
      if (rst) begin
         st_m_q   <= '0;
         st_s_q   <= '0;
         fl_m_q   <= '0;
         fl_s_q   <= '0;
         st_lvl_q <= 1'b0;
         fl_lvl_q <= 1'b0;
      end else begin
         st_m_q   <= ev_start_in;
         st_s_q   <= st_m_q;
         fl_m_q   <= ev_flush_in;
         fl_s_q   <= fl_m_q;
         st_lvl_q <= st_lvl;
         fl_lvl_q <= fl_lvl;
      end
   end

   assign st_lvl = (|st_s_q) ^ evc_q.start_invert;
   assign fl_lvl = (|fl_s_q) ^ evc_q.flush_invert;

   assign flush_req = (fl_lvl && !fl_lvl_q && evc_q.flush_in) || trig_pend_q[adcc_pkg::ST_FLUSH];
   assign start_req = ((st_lvl && !st_lvl_q && evc_q.start_in) || trig_pend_q[adcc_pkg::ST_START])
                      && !flush_req;

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer with power control
   assign conv_end = (state_q == adcc_pkg::ST_CONV) && core_result_valid && core_avg_last;

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q      <= adcc_pkg::ST_OFF;
         warm_q       <= '0;
         pend_start_q <= 1'b0;
         core_start   <= 1'b0;
         core_flush   <= 1'b0;
      end else begin
         core_start <= 1'b0;
         core_flush <= flush_req && run_ok;
         case (state_q)
            adcc_pkg::ST_OFF: begin
               if (run_ok && (!ctrl_a_q[adcc_pkg::CA_ON_REQUEST] || start_req)) begin
                  state_q      <= adcc_pkg::ST_WARM;
                  warm_q       <= ($bits(warm_q))'(STARTUP);
                  pend_start_q <= start_req;
               end
            end
            adcc_pkg::ST_WARM: begin
               if (!run_ok) state_q <= adcc_pkg::ST_OFF;
               else begin
                  if (start_req) pend_start_q <= 1'b1;
                  if (flush_req) pend_start_q <= 1'b0;
                  if (warm_q > ($bits(warm_q))'(1)) warm_q <= warm_q - 1'b1;
                  else if ((pend_start_q || start_req) && !flush_req) begin
                     state_q    <= adcc_pkg::ST_CONV;
                     core_start <= 1'b1;
                  end else if (ctrl_a_q[adcc_pkg::CA_ON_REQUEST] && flush_req) state_q <= adcc_pkg::ST_OFF;
                  else state_q <= adcc_pkg::ST_READY;
               end
            end
            adcc_pkg::ST_READY: begin
               if (!run_ok) state_q <= adcc_pkg::ST_OFF;
               else if (start_req) begin
                  state_q    <= adcc_pkg::ST_CONV;
                  core_start <= 1'b1;
               end
            end
            adcc_pkg::ST_CONV: begin
               if (!run_ok) state_q <= adcc_pkg::ST_OFF;
               else if (conv_end || flush_req) begin
                  // on-request mode drops analog power after every conversion
                  state_q <= ctrl_a_q[adcc_pkg::CA_ON_REQUEST] ? adcc_pkg::ST_OFF : adcc_pkg::ST_READY;
               end
            end
            default: state_q <= adcc_pkg::ST_OFF;
         endcase
      end
   end

   assign core_power = (state_q != adcc_pkg::ST_OFF);

   ////////////////////////////////////////////////////////////////////////////
   // results: only the last sample of an averaging run enters the fifo
   assign push = core_result_valid && core_avg_last && core_result_ready;
   assign flag_set.result_ready = push;
   assign flag_set.window_match = push && core_window_match;
   assign flag_set.overrun      = core_result_valid && core_avg_last && !core_result_ready;

   adcc_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (srst),
      .flush     (1'b0),
      .in_valid  (core_result_valid && core_avg_last),
      .in_ready  (core_result_ready),
      .in_data   (core_result_data),
      .out_valid (fifo_valid),
      .out_ready (rd_acc && idx == adcc_pkg::IDX_RESULT),
      .out_data  (fifo_data)
   );

   assign dma_request = fifo_valid;

   // output events, one-cycle pulses
   always_ff @(posedge clk) begin
      if (srst) begin
         ev_result_ready_out <= 1'b0;
         ev_window_match_out <= 1'b0;
      end else begin
         ev_result_ready_out <= push && evc_q.result_ready_out;
         ev_window_match_out <= push && core_window_match && evc_q.window_match_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped words read zero
   always_comb begin
      rdata = '0;
      case (idx)
         adcc_pkg::IDX_CONTROL_A:     rdata[7:0]  = {ctrl_a_q[7:2], enable_q, sr_pend_q};
         adcc_pkg::IDX_EVENT_CONTROL: rdata[5:0]  = evc_q;
         adcc_pkg::IDX_IRQ_EN_CLEAR:  rdata[2:0]  = irq_en_q;
         adcc_pkg::IDX_IRQ_EN_SET:    rdata[2:0]  = irq_en_q;
         adcc_pkg::IDX_IRQ_FLAGS:     rdata[2:0]  = flags_q;
         adcc_pkg::IDX_SYNC_BUSY:     rdata[10:0] = sync_busy;
         adcc_pkg::IDX_RESULT:        rdata[15:0] = fifo_valid ? fifo_data : 16'h0000;
         default: begin
            for (int i = 0; i < adcc_pkg::NUM_BUF; i++) begin
               if (idx == adcc_pkg::BUF_IDX[i]) rdata[15:0] = shadow_q[i];
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) avs_readdata <= '0;
      else if (avs_read && !ack_q) avs_readdata <= rdata;
   end
endmodule : adcc_ctrl

/* rtl/adcc_pkg.sv */
// adcc_pkg: constants and types of the converter control wrapper
// assumes a 32-bit Avalon-MM slave, one register per aligned word, byte address = 4 * index
package adcc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL_A      = 8'h00;
   localparam logic [7:0] IDX_EVENT_CONTROL  = 8'h03;
   localparam logic [7:0] IDX_IRQ_EN_CLEAR   = 8'h04;
   localparam logic [7:0] IDX_IRQ_EN_SET     = 8'h05;
   localparam logic [7:0] IDX_IRQ_FLAGS      = 8'h06;
   localparam logic [7:0] IDX_INPUT_SELECT   = 8'h08;
   localparam logic [7:0] IDX_CONTROL_C      = 8'h0a;
   localparam logic [7:0] IDX_AVERAGING      = 8'h0c;
   localparam logic [7:0] IDX_SAMPLE_TIME    = 8'h0d;
   localparam logic [7:0] IDX_WIN_LOW        = 8'h0e;
   localparam logic [7:0] IDX_WIN_HIGH       = 8'h10;
   localparam logic [7:0] IDX_GAIN_CORR      = 8'h12;
   localparam logic [7:0] IDX_OFFSET_CORR    = 8'h14;
   localparam logic [7:0] IDX_SOFT_TRIGGER   = 8'h18;
   localparam logic [7:0] IDX_SYNC_BUSY      = 8'h20;
   localparam logic [7:0] IDX_RESULT         = 8'h24;

   // control_a fields
   localparam int CA_SOFT_RESET = 0;
   localparam int CA_ENABLE     = 1;
   localparam int CA_RUN_STDBY  = 6;
   localparam int CA_ON_REQUEST = 7;
   localparam logic [7:0] CA_MASK = 8'hc3;

   // soft_trigger fields
   localparam int ST_FLUSH = 0;
   localparam int ST_START = 1;

   // sync_busy bit positions; buffered registers occupy bits 2..9 in index order
   localparam int SB_SOFT_RESET = 0;
   localparam int SB_ENABLE     = 1;
   localparam int SB_BUF_BASE   = 2;
   localparam int SB_SOFT_TRIG  = 10;
   localparam int NUM_BUF       = 8;

   // double-buffered register table: index and implemented bits
   localparam logic [NUM_BUF-1:0][7:0] BUF_IDX = {IDX_OFFSET_CORR, IDX_GAIN_CORR, IDX_WIN_HIGH, IDX_WIN_LOW,
                                                  IDX_SAMPLE_TIME, IDX_AVERAGING, IDX_CONTROL_C, IDX_INPUT_SELECT};
   localparam logic [NUM_BUF-1:0][15:0] BUF_MASK = {16'h0fff, 16'h0fff, 16'hffff, 16'hffff,
                                                   16'h00bf, 16'h007f, 16'h3fff, 16'h1f1f};

   // timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SYNC_STAGES    = 2;      // converter-side transfer latency in cycles
   localparam int STARTUP_NS     = 1000;   // analog start-up delay
   localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // interrupt sources
   typedef struct packed {
      logic window_match;
      logic overrun;
      logic result_ready;
   } adcc_irq_t;

   // event control fields
   typedef struct packed {
      logic window_match_out;
      logic result_ready_out;
      logic start_invert;
      logic flush_invert;
      logic start_in;
      logic flush_in;
   } adcc_event_control_t;

   // conversion sequencer states
   typedef enum logic [1:0] {
      ST_OFF,
      ST_WARM,
      ST_READY,
      ST_CONV
   } adcc_state_t;
endpackage : adcc_pkg

/* test/adcc_core_model.sv */
// adcc_core_model: behavioural analog core, two samples per result
// assumes one-cycle start and flush pulses
`timescale 1ns/1ps
module adcc_core_model (
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         core_power,
   input wire logic         core_start,
   input wire logic         core_flush,
   input wire logic         win,
   output logic             core_result_valid,
   output logic             core_avg_last,
   output logic             core_window_match,
   output logic      [15:0] core_result_data
);
   logic [3:0]  cnt_q;
   logic [15:0] num_q;
   // conversion timer, cut short by flush or power loss
   always_ff @(posedge clk) begin
      if (rst || core_flush || !core_power) cnt_q <= 4'h0;
      else if (core_start) cnt_q <= 4'h8;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   end
   // result numbers; off-result cycles show a toggling pattern
   always_ff @(posedge clk) begin
      if (rst) num_q <= 16'h0100;
      else if (core_avg_last) num_q <= num_q + 16'h0001;
   end
   assign core_result_valid = (cnt_q == 4'h5) || core_avg_last;
   assign core_avg_last = (cnt_q == 4'h1);
   assign core_window_match = core_avg_last & win;
   assign core_result_data = core_avg_last ? num_q : ~num_q ^ {12'h000, cnt_q};
endmodule : adcc_core_model

/* test/adcc_ctrl_bench.sv */
// adcc_ctrl_bench: directed bus sequences against adcc_ctrl
// assumes package, design, monitor and core model compiled first
`timescale 1ns/1ps
module adcc_ctrl_bench;
   logic        clk, rst, avs_read, avs_write, avs_waitrequest, dma_request, irq, wake_request;
   logic        standby, win, ev_result_ready_out, ev_window_match_out, core_power, core_start;
   logic        core_flush, core_result_ready, core_result_valid, core_avg_last, core_window_match;
   logic [0:0]  ev_start_in, ev_flush_in;
   logic [9:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat;
   logic [15:0] core_result_data;
   logic [adcc_pkg::NUM_BUF-1:0][15:0] core_config;
   int          num_errors, check_count, i;
   adcc_ctrl #(.STARTUP(2)) u_adcc_ctrl (.*);
   adcc_core_model u_adcc_core_model (.*);
   // one bus access, held until waitrequest is seen low
   task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= {idx, 2'b00};
      avs_writedata <= wd;
      @(posedge clk);
      while (avs_waitrequest) @(posedge clk);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : acc
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic res_wait;
      @(posedge clk);
      while (!(core_result_valid && core_avg_last)) @(posedge clk);
   endtask : res_wait
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   initial begin
      #300us;
      num_errors++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      {rst, avs_read, avs_write, standby, win, ev_start_in, ev_flush_in} = 7'h40;
      avs_address = 10'h000;
      avs_writedata = 32'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      acc(0, 8'h06, 32'h0);
      chk("flags", rdat, 32'h0);
      acc(1, 8'h05, 32'h5);
      acc(1, 8'h05, 32'h0);
      acc(1, 8'h04, 32'h1);
      acc(0, 8'h05, 32'h0);
      chk("enables", rdat, 32'h4);
      acc(0, 8'h3f, 32'h0);
      chk("unmapped", rdat, 32'h0);
      acc(1, 8'h05, 32'h3);
      $display("test registers done");
      acc(1, 8'h00, 32'h2);
      acc(1, 8'h18, 32'h2);
      res_wait();
      @(negedge clk);
      chk("dma up", dma_request, 32'h1);
      chk("irq up", irq, 32'h1);
      chk("no event", ev_result_ready_out, 32'h0);
      acc(0, 8'h24, 32'h0);
      chk("result", rdat, 32'h100);
      acc(1, 8'h06, 32'h7);
      @(negedge clk);
      chk("dma down", dma_request, 32'h0);
      chk("irq down", irq, 32'h0);
      $display("test result done");
      win <= 1'b1;
      acc(1, 8'h03, 32'h32);
      ev_start_in <= 1'b1;
      res_wait();
      win <= 1'b0;
      @(negedge clk);
      chk("res event", ev_result_ready_out, 32'h1);
      chk("win event", ev_window_match_out, 32'h1);
      acc(0, 8'h06, 32'h0);
      chk("win flags", rdat, 32'h5);
      acc(0, 8'h24, 32'h0);
      acc(1, 8'h03, 32'h3a);
      acc(1, 8'h06, 32'h7);
      repeat (9) @(posedge clk);
      chk("no start", dma_request, 32'h0);
      ev_start_in <= 1'b0;
      res_wait();
      acc(0, 8'h24, 32'h0);
      chk("falling", rdat, 32'h102);
      acc(1, 8'h03, 32'h3);
      {ev_start_in, ev_flush_in} <= 2'b11;
      repeat (20) @(posedge clk);
      chk("flush wins", dma_request, 32'h0);
      {ev_start_in, ev_flush_in} <= 2'b00;
      acc(1, 8'h18, 32'h2);
      ev_flush_in <= 1'b1;
      repeat (20) @(posedge clk);
      chk("flushed", dma_request, 32'h0);
      ev_flush_in <= 1'b0;
      $display("test events done");
      for (i = 0; i < 17; i++) begin
         acc(1, 8'h18, 32'h2);
         res_wait();
      end
      @(negedge clk);
      chk("full", core_result_ready, 32'h0);
      acc(0, 8'h06, 32'h0);
      chk("overrun", rdat, 32'h3);
      for (i = 0; i < 16; i++) begin
         acc(0, 8'h24, 32'h0);
         chk("drain", rdat, 32'h103 + i);
      end
      @(negedge clk);
      chk("empty", dma_request, 32'h0);
      $display("test fifo done");
      acc(1, 8'h00, 32'h82);
      acc(1, 8'h18, 32'h2);
      res_wait();
      repeat (3) @(posedge clk);
      chk("power off", core_power, 32'h0);
      acc(1, 8'h00, 32'h2);
      standby <= 1'b1;
      repeat (5) @(posedge clk);
      chk("standby", core_power, 32'h0);
      chk("wake", wake_request, 32'h1);
      standby <= 1'b0;
      acc(0, 8'h20, 32'h0);
      chk("trig busy", rdat, 32'h400);
      acc(1, 8'h18, 32'h2);
      acc(1, 8'h0e, 32'h1234);
      acc(0, 8'h20, 32'h0);
      chk("buf busy", rdat, 32'h440);
      res_wait();
      repeat (2) @(posedge clk);
      chk("config", core_config[4], 32'h1234);
      acc(0, 8'h20, 32'h0);
      chk("idle", rdat, 32'h0);
      acc(0, 8'h24, 32'h0);
      acc(0, 8'h24, 32'h0);
      chk("last", rdat, 32'h115);
      $display("test sleep done");
      // soft reset: busy while it crosses, then the interrupt enables cleared
      acc(1, 8'h00, 32'h1);
      acc(0, 8'h20, 32'h0);
      chk("reset busy", rdat, 32'h3);
      acc(0, 8'h05, 32'h0);
      chk("reset enables", rdat, 32'h0);
      acc(1, 8'h00, 32'h42);
      standby <= 1'b1;
      repeat (6) @(posedge clk);
      chk("run standby", core_power, 32'h1);
      standby <= 1'b0;
      $display("test reset done");
      end_of_test();
   end
endmodule : adcc_ctrl_bench
bind adcc_ctrl adcc_ctrl_monitor u_adcc_ctrl_monitor (.*);

/* test/adcc_ctrl_monitor.sv */
// adcc_ctrl_monitor: port timing checks of adcc_ctrl
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module adcc_ctrl_monitor (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [9:0] avs_address,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       dma_request,
   input wire logic       irq,
   input wire logic       wake_request,
   input wire logic       standby,
   input wire logic       ev_result_ready_out,
   input wire logic       core_power,
   input wire logic       core_start,
   input wire logic       core_flush,
   input wire logic       core_result_valid,
   input wire logic       core_avg_last,
   input wire logic       core_result_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // a counted result entering the fifo, and an accepted result read
   wire push = core_result_valid & core_avg_last & core_result_ready;
   wire pop = avs_read & !avs_waitrequest & (avs_address[9:2] == adcc_pkg::IDX_RESULT);
   ////////////////////////////////////////////////////////////
   bus_wait_a: assert property ((avs_read | avs_write) && !$past(avs_read | avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
   dma_rise_a: assert property (push |=> dma_request)
      else $error("dma request missing");
   dma_fall_a: assert property ($fell(dma_request) |-> $past(pop))
      else $error("dma request dropped without read");
   avg_gate_a: assert property (!dma_request && !push |=> !dma_request)
      else $error("dma request without result");
   res_event_a: assert property (ev_result_ready_out |-> $past(core_result_valid && core_avg_last))
      else $error("result event without result");
   start_power_a: assert property (core_start |-> core_power)
      else $error("start while powered down");
   flush_first_a: assert property (core_flush |-> !core_start)
      else $error("start beside flush");
   wake_src_a: assert property (wake_request |-> standby && irq)
      else $error("wake outside standby");
endmodule : adcc_ctrl_monitor
